// File: hw/bwo_adder.sv
`timescale 1ns/1ps
// =====================================================================
// Sixteen-bit adder with an optional ones complement memory side.
// =====================================================================
module bwo_adder (
   input wire logic [15:0] i_s_bus,  // Accumulator side, always full.
   input wire logic [15:0] i_r_reg,  // Operand holding register.
   input wire logic i_subtract,      // Complement operand, carry in.
   output logic [15:0] o_sum,        // Adder result.
   output logic o_overflow           // Signed overflow of the result.
);

   // ==================================================================
   // Adder inputs.
   // ==================================================================
   logic [15:0] u_bus; // Memory side of the adder.
   logic carry_in;     // Initial carry.
   logic [16:0] wide;  // Sum with carry out.

   // Subtraction adds the twos complement made from ones complement
   // plus an initial carry, so no separate subtractor is needed.
   always_comb begin
      u_bus = i_subtract ? ~i_r_reg : i_r_reg;
      carry_in = i_subtract;
      wide = {1'b0, i_s_bus} + {1'b0, u_bus} + {16'h0000, carry_in};
      o_sum = wide[15:0];
      o_overflow = (i_s_bus[15] == u_bus[15]) &&
                   (o_sum[15] != i_s_bus[15]);
   end

endmodule : bwo_adder

// File: hw/bwo_byte_pick.sv
`timescale 1ns/1ps
// =====================================================================
// Byte extraction: picks one half of a word and zero-extends it.
// =====================================================================
module bwo_byte_pick (
   input wire logic [15:0] i_word,  // Word read from memory.
   input wire logic i_sel,          // Byte selector from the address.
   input wire logic i_byte,         // High for a byte access.
   output logic [15:0] o_data       // Word or zero-extended byte.
);

   // ==================================================================
   // Selection.
   // ==================================================================
   // Selector zero names the most significant half of the word.
   always_comb begin
      o_data = i_word;
      if (i_byte) begin
         if (i_sel == bwo_pkg::SEL_HIGH_BYTE) begin
            o_data = {8'h00, i_word[15:8]};
         end else begin
            o_data = {8'h00, i_word[7:0]};
         end
      end
   end

endmodule : bwo_byte_pick

// File: hw/bwo_operand_access.sv
`timescale 1ns/1ps
module bwo_operand_access #(
   parameter int DATA_W = 16 // Word width; only 16 is served.
) (
   input wire logic i_core_clk,             // Processor clock, 25 MHz.
   input wire logic i_rst_b,                // Asynchronous reset, low.
   input wire logic i_console_reset,        // Processor reset pulse.
   input wire logic i_set_byte_mode,        // Byte mode control pulse.
   input wire logic i_set_word_mode,        // Word mode control pulse.
   input wire logic i_req_valid,            // Request strobe.
   input wire bwo_pkg::bwo_req_s i_req,     // Request contents.
   input wire logic [15:0] i_acc,           // Accumulator contents.
   input wire logic [15:0] i_mem_rdata,     // Memory read data.
   input wire logic i_mem_ack,              // Memory read done pulse.
   output logic o_req_ready,                // Block is idle.
   output bwo_pkg::bwo_mem_s o_mem,         // Memory read request.
   output logic o_done,                     // Result valid pulse.
   output logic o_acc_wr,                   // Write accumulator pulse.
   output logic [15:0] o_result,            // Data for the register.
   output logic [15:0] o_target,            // Resolved operand address.
   output logic [15:0] o_next_byte_addr,    // Following byte address.
   output logic o_byte_mode,                // Mode state, high for byte.
   output logic o_overflow                  // Overflow flag.
);

   // ==================================================================
   // Parameter check.
   // ==================================================================
   // The byte split and address formats are fixed at sixteen bits.
   if (DATA_W != bwo_pkg::WORD_W) begin : g_bad_width
      $error("bwo_operand_access serves only 16-bit words");
   end

   // ==================================================================
   // Reset synchroniser.
   // ==================================================================
   logic rst_meta_ff; // First stage, read only by the second.
   logic rst_sync_ff; // Released reset, active high.

   // Reset asserts at once and releases two edges later.
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= 1'b1;
      end else begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ==================================================================
   // Mode and overflow state.
   // ==================================================================
   logic byte_mode_ff; // High while in byte mode.
   logic nxt_byte_mode;
   logic overflow_ff;  // Overflow flip-flop.
   logic nxt_overflow;
   logic add_ovf;      // Overflow from the adder.
   logic arith_fin;    // Arithmetic result lands this cycle.

   // Console reset wins over a mode pulse in the same cycle, since it
   // must always leave the processor in a known mode.
   always_comb begin
      nxt_byte_mode = byte_mode_ff;
      nxt_overflow = overflow_ff;
      if (i_set_byte_mode) begin
         nxt_byte_mode = 1'b1;
      end else if (i_set_word_mode) begin
         nxt_byte_mode = 1'b0;
      end
      if (arith_fin && add_ovf) begin
         nxt_overflow = 1'b1;
      end
      if (i_console_reset) begin
         nxt_byte_mode = bwo_pkg::RST_BYTE_MODE;
         nxt_overflow = bwo_pkg::RST_OVERFLOW;
      end
   end

   // Registers the mode state.
   always_ff @(posedge i_core_clk or posedge rst_sync_ff) begin
      if (rst_sync_ff) begin
         byte_mode_ff <= bwo_pkg::RST_BYTE_MODE;
         overflow_ff <= bwo_pkg::RST_OVERFLOW;
      end else begin
         byte_mode_ff <= nxt_byte_mode;
         overflow_ff <= nxt_overflow;
      end
   end

   // ==================================================================
   // Address format helpers.
   // ==================================================================
   // Word address of a word-format value: bit 15 forced to zero.
   function automatic logic [15:0] word_addr(input logic [15:0] a);
      word_addr = {1'b0, a[14:0]};
   endfunction : word_addr

   // Word address holding a byte-format value: location in bits 1-15.
   function automatic logic [15:0] byte_word_addr(input logic [15:0] a);
      byte_word_addr = {1'b0, a[15:1]};
   endfunction : byte_word_addr

   // Byte access applies only to data operations in byte mode.
   function automatic logic uses_byte(input bwo_pkg::bwo_op_e op,
                                      input logic mode);
      uses_byte = mode && (op == bwo_pkg::OP_LOAD ||
                           op == bwo_pkg::OP_ADD ||
                           op == bwo_pkg::OP_SUB ||
                           op == bwo_pkg::OP_READ);
   endfunction : uses_byte

   // Jumps resolve an address and read no operand.
   function automatic logic is_jump(input bwo_pkg::bwo_op_e op);
      is_jump = (op == bwo_pkg::OP_JUMP_INSTR) ||
                (op == bwo_pkg::OP_JUMP_AND_STORE_INSTR);
   endfunction : is_jump

   // ==================================================================
   // Operand sequencer.
   // ==================================================================
   bwo_pkg::bwo_state_e state_ff; // Sequencer state.
   bwo_pkg::bwo_state_e nxt_state;
   bwo_pkg::bwo_op_e op_ff;       // Operation in progress.
   bwo_pkg::bwo_op_e nxt_op;
   logic byte_acc_ff;             // This operand is a byte.
   logic nxt_byte_acc;
   logic [15:0] opnd_addr_ff;     // Operand address, current format.
   logic [15:0] nxt_opnd_addr;
   logic [15:0] mem_addr_ff;      // Address on the memory port.
   logic [15:0] nxt_mem_addr;
   logic mem_rd_ff;               // Memory read strobe.
   logic nxt_mem_rd;
   logic [15:0] r_reg_ff;         // Operand holding register.
   logic [15:0] nxt_r_reg;
   logic [15:0] result_ff;        // Result for the register file.
   logic [15:0] nxt_result;
   logic [15:0] target_ff;        // Resolved operand address.
   logic [15:0] nxt_target;
   logic [15:0] next_byte_ff;     // Following byte address.
   logic [15:0] nxt_next_byte;
   logic done_ff;                 // Result valid pulse.
   logic nxt_done;
   logic acc_wr_ff;               // Accumulator write pulse.
   logic nxt_acc_wr;
   logic [15:0] picked;           // Word or zero-extended byte.
   logic [15:0] sum;              // Adder output.

   // Byte extraction from the word read in the operand cycle.
   bwo_byte_pick u_pick (
      .i_word (i_mem_rdata),
      .i_sel (opnd_addr_ff[bwo_pkg::BYTE_SEL_BIT]),
      .i_byte (byte_acc_ff),
      .o_data (picked)
   );

   // Adder sees the full accumulator against the holding register.
   bwo_adder u_adder (
      .i_s_bus (i_acc),
      .i_r_reg (r_reg_ff),
      .i_subtract (op_ff == bwo_pkg::OP_SUB),
      .o_sum (sum),
      .o_overflow (add_ovf)
   );

   // Arithmetic results are written in the cycle after the operand
   // lands, once the holding register has been loaded.
   assign arith_fin = (state_ff == bwo_pkg::ST_DONE) &&
                      (op_ff == bwo_pkg::OP_ADD || op_ff == bwo_pkg::OP_SUB);

   // Next-state logic for the sequencer and its data registers.
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_byte_acc = byte_acc_ff;
      nxt_opnd_addr = opnd_addr_ff;
      nxt_mem_addr = mem_addr_ff;
      nxt_mem_rd = mem_rd_ff;
      nxt_r_reg = r_reg_ff;
      nxt_result = result_ff;
      nxt_target = target_ff;
      nxt_next_byte = next_byte_ff;
      nxt_done = 1'b0;
      nxt_acc_wr = 1'b0;
      unique case (state_ff)
         bwo_pkg::ST_IDLE: begin
            if (i_req_valid) begin
               nxt_op = i_req.op;
               nxt_byte_acc = uses_byte(i_req.op, byte_mode_ff);
               if (i_req.indirect && i_req.op != bwo_pkg::OP_FETCH) begin
                  // Pointer reads are word reads in either mode.
                  nxt_mem_addr = word_addr(i_req.addr);
                  nxt_mem_rd = 1'b1;
                  nxt_state = bwo_pkg::ST_POINTER;
               end else if (is_jump(i_req.op)) begin
                  nxt_target = word_addr(i_req.addr);
                  nxt_done = 1'b1;
                  nxt_state = bwo_pkg::ST_IDLE;
               end else begin
                  nxt_opnd_addr = i_req.addr;
                  nxt_target = i_req.addr;
                  if (uses_byte(i_req.op, byte_mode_ff)) begin
                     nxt_mem_addr = byte_word_addr(i_req.addr);
                  end else begin
                     nxt_mem_addr = word_addr(i_req.addr);
                  end
                  nxt_mem_rd = 1'b1;
                  nxt_state = bwo_pkg::ST_OPERAND;
               end
            end
         end
         bwo_pkg::ST_POINTER: begin
            if (i_mem_ack) begin
               if (byte_acc_ff) begin
                  // A byte pointer ends the chain after one level.
                  nxt_opnd_addr = i_mem_rdata;
                  nxt_target = i_mem_rdata;
                  nxt_mem_addr = byte_word_addr(i_mem_rdata);
                  nxt_state = bwo_pkg::ST_OPERAND;
               end else if (i_mem_rdata[bwo_pkg::WORD_MSB]) begin
                  // One further read per level; no limit on depth.
                  nxt_mem_addr = word_addr(i_mem_rdata);
                  nxt_state = bwo_pkg::ST_POINTER;
               end else begin
                  nxt_opnd_addr = word_addr(i_mem_rdata);
                  nxt_target = word_addr(i_mem_rdata);
                  nxt_mem_addr = word_addr(i_mem_rdata);
                  nxt_state = bwo_pkg::ST_OPERAND;
               end
               if (is_jump(op_ff) && !byte_acc_ff &&
                   !i_mem_rdata[bwo_pkg::WORD_MSB]) begin
                  nxt_mem_rd = 1'b0;
                  nxt_done = 1'b1;
                  nxt_state = bwo_pkg::ST_IDLE;
               end
            end
         end
         bwo_pkg::ST_OPERAND: begin
            if (i_mem_ack) begin
               nxt_mem_rd = 1'b0;
               nxt_r_reg = picked;
               if (byte_acc_ff) begin
                  // Sequential bytes pack two per word.
                  nxt_next_byte = opnd_addr_ff + bwo_pkg::ONE_WORD;
               end else begin
                  nxt_next_byte = opnd_addr_ff;
               end
               if (op_ff == bwo_pkg::OP_ADD || op_ff == bwo_pkg::OP_SUB) begin
                  nxt_state = bwo_pkg::ST_DONE;
               end else begin
                  nxt_result = picked;
                  nxt_done = 1'b1;
                  nxt_state = bwo_pkg::ST_IDLE;
               end
            end
         end
         bwo_pkg::ST_DONE: begin
            nxt_result = sum;
            nxt_acc_wr = 1'b1;
            nxt_done = 1'b1;
            nxt_state = bwo_pkg::ST_IDLE;
         end
      endcase
      // Console reset aborts any access in flight, read strobe included.
      if (i_console_reset) begin
         nxt_state = bwo_pkg::ST_IDLE;
         nxt_mem_rd = 1'b0;
         nxt_done = 1'b0;
         nxt_acc_wr = 1'b0;
      end
   end

   // Registers the sequencer. Data registers are not cleared by the
   // console reset, which only touches control flip-flops.
   always_ff @(posedge i_core_clk or posedge rst_sync_ff) begin
      if (rst_sync_ff) begin
         state_ff <= bwo_pkg::ST_IDLE;
         op_ff <= bwo_pkg::OP_FETCH;
         byte_acc_ff <= 1'b0;
         opnd_addr_ff <= bwo_pkg::ZERO_WORD;
         mem_addr_ff <= bwo_pkg::ZERO_WORD;
         mem_rd_ff <= 1'b0;
         r_reg_ff <= bwo_pkg::ZERO_WORD;
         result_ff <= bwo_pkg::ZERO_WORD;
         target_ff <= bwo_pkg::ZERO_WORD;
         next_byte_ff <= bwo_pkg::ZERO_WORD;
         done_ff <= 1'b0;
         acc_wr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         byte_acc_ff <= nxt_byte_acc;
         opnd_addr_ff <= nxt_opnd_addr;
         mem_addr_ff <= nxt_mem_addr;
         mem_rd_ff <= nxt_mem_rd;
         r_reg_ff <= nxt_r_reg;
         result_ff <= nxt_result;
         target_ff <= nxt_target;
         next_byte_ff <= nxt_next_byte;
         done_ff <= nxt_done;
         acc_wr_ff <= nxt_acc_wr;
      end
   end

   // ==================================================================
   // Outputs.
   // ==================================================================
   // Ready is combinational so a request can follow a done pulse.
   assign o_req_ready = (state_ff == bwo_pkg::ST_IDLE);
   assign o_mem.rd = mem_rd_ff;
   assign o_mem.addr = mem_addr_ff;
   assign o_done = done_ff;
   assign o_acc_wr = acc_wr_ff;
   assign o_result = result_ff;
   assign o_target = target_ff;
   assign o_next_byte_addr = next_byte_ff;
   assign o_byte_mode = byte_mode_ff;
   assign o_overflow = overflow_ff;

endmodule : bwo_operand_access

// File: hw/bwo_pkg.sv
// =====================================================================
// Shared constants and types for the byte/word operand access logic.
// =====================================================================
package bwo_pkg;

   // ==================================================================
   // Widths and field positions.
   // ==================================================================
   localparam int WORD_W = 16;          // Memory and register word width.
   localparam int BYTE_W = 8;           // Byte width, bits 0 to 7.
   localparam int WADDR_W = 15;         // Word location width.
   localparam int WORD_MSB = 15;        // Sign or chain bit of a word.
   localparam int BYTE_SEL_BIT = 0;     // Byte selector in a byte address.
   localparam int WORD_CAPACITY = 32768; // Words reachable in memory.
   localparam int BYTE_CAPACITY = 65536; // Bytes reachable in memory.

   // ==================================================================
   // Reset and encoding values.
   // ==================================================================
   localparam logic RST_BYTE_MODE = 1'h0; // Word mode after reset.
   localparam logic RST_OVERFLOW = 1'h0;  // Overflow clear after reset.
   localparam logic SEL_HIGH_BYTE = 1'h0; // Selector value for byte 0.
   localparam logic [15:0] ZERO_WORD = 16'h0000; // Cleared word.
   localparam logic [15:0] ONE_WORD = 16'h0001;  // Byte address step.

   // Kinds of access that the sequencer asks for.
   typedef enum logic [3:0] {
      OP_FETCH = 4'h0,                       // Instruction fetch.
      OP_LOAD = 4'h1,                        // Register load.
      OP_ADD = 4'h2,                         // Add to accumulator.
      OP_SUB = 4'h3,                         // Subtract from accumulator.
      OP_INCREMENT_MEMORY_SKIP_INSTR = 4'h4, // Always a word read.
      OP_MEMORY_SCAN_INSTR = 4'h5,           // Always a word read.
      OP_JUMP_INSTR = 4'h6,                  // Target address only.
      OP_JUMP_AND_STORE_INSTR = 4'h7,        // Target address only.
      OP_READ = 4'h8                         // Plain operand read.
   } bwo_op_e;

   // Operand cycle sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,    // Waiting for a request.
      ST_POINTER = 2'b01, // Reading an indirect pointer.
      ST_OPERAND = 2'b10, // Reading the operand.
      ST_DONE = 2'b11     // Presenting the result.
   } bwo_state_e;

   // Request from the instruction sequencer.
   typedef struct packed {
      bwo_op_e op;          // Kind of access.
      logic indirect;       // Follow a pointer first.
      logic [15:0] addr;    // Effective address in the current format.
   } bwo_req_s;

   // Read request toward main memory.
   typedef struct packed {
      logic rd;             // Read strobe, held until acknowledged.
      logic [15:0] addr;    // Word address, bit 15 always zero.
   } bwo_mem_s;

endpackage : bwo_pkg

// File: verif/bwo_mem_model.sv
`timescale 1ns/1ps
// =====================================================================
// Main memory of 16-bit words, prompt or slow to answer.
// =====================================================================
module bwo_mem_model (
   input wire logic i_clk, // Core clock.
   input wire logic i_rst_b, // Reset, low.
   input wire bwo_pkg::bwo_mem_s i_mem, // Read request.
   input wire logic i_slow, // High adds wait cycles.
   output logic o_ack, // Read done pulse.
   output logic [15:0] o_rdata // Read data, valid with o_ack.
);
   logic [15:0] words [0:32767]; // Full 32K word store.
   logic [1:0] wait_ff; // Wait cycles spent on this read.
   // Between answers the data lines toggle, so stale data never matches.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_ack <= 1'h0;
         o_rdata <= 16'hA5A5;
         wait_ff <= 2'h0;
      end else begin
         o_ack <= 1'h0;
         o_rdata <= ~o_rdata;
         if (i_mem.rd && !o_ack) begin
            if (wait_ff == (i_slow ? 2'h3 : 2'h0)) begin
               o_ack <= 1'h1;
               o_rdata <= words[i_mem.addr[14:0]];
               wait_ff <= 2'h0;
            end else begin
               wait_ff <= wait_ff + 2'h1;
            end
         end
      end
   end
endmodule : bwo_mem_model

// File: verif/bwo_operand_access_monitor.sv
`timescale 1ns/1ps
// =====================================================================
// Port checker: mode state, address format and read handshake.
// =====================================================================
module bwo_operand_access_monitor (
   input wire logic i_core_clk, // Clock.
   input wire logic i_rst_b, // Reset, low.
   input wire logic i_console_reset, // Processor reset pulse.
   input wire logic i_set_byte_mode, // Byte mode pulse.
   input wire logic i_set_word_mode, // Word mode pulse.
   input wire logic i_req_valid, // Request strobe.
   input wire bwo_pkg::bwo_req_s i_req, // Request contents.
   input wire logic i_mem_ack, // Read done pulse.
   input wire logic o_req_ready, // Idle.
   input wire bwo_pkg::bwo_mem_s o_mem, // Memory request.
   input wire logic o_done, // Result pulse.
   input wire logic o_acc_wr, // Accumulator write.
   input wire logic o_byte_mode, // Mode state.
   input wire logic o_overflow // Overflow flag.
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   // A console reset aborts everything, so next-cycle causes below exclude it, except the word mode check, whose outcome it cannot change, and the console check.
   a_word_addr_msb: assert property (o_mem.rd |-> !o_mem.addr[15])
      else $error("memory address bit 15 set");
   a_read_held: assert property (o_mem.rd && !i_mem_ack &&
      !i_console_reset |=> o_mem.rd) else $error("read dropped early");
   a_acc_wr_done: assert property (o_acc_wr |-> o_done)
      else $error("accumulator write outside done");
   a_byte_mode_set: assert property (i_set_byte_mode &&
      !i_console_reset |=> o_byte_mode) else $error("byte mode missed");
   a_word_mode_set: assert property (i_set_word_mode &&
      !i_set_byte_mode |=> !o_byte_mode) else $error("word mode missed");
   a_mode_kept: assert property (!i_set_byte_mode &&
      !i_set_word_mode && !i_console_reset |=> $stable(o_byte_mode))
      else $error("mode changed by itself");
   a_console_clear: assert property (i_console_reset |=>
      !o_byte_mode && !o_overflow && !o_mem.rd)
      else $error("processor reset incomplete");
   a_overflow_sticky: assert property (o_overflow &&
      !i_console_reset |=> o_overflow) else $error("overflow lost");
   a_fetch_word: assert property (i_req_valid && o_req_ready &&
      i_req.op == bwo_pkg::OP_FETCH && !i_console_reset |=> o_mem.rd &&
      o_mem.addr == {1'h0, $past(i_req.addr[14:0])})
      else $error("fetch not a word read");
endmodule : bwo_operand_access_monitor

bind bwo_operand_access bwo_operand_access_monitor mon (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
   .i_console_reset(i_console_reset), .i_set_byte_mode(i_set_byte_mode),
   .i_set_word_mode(i_set_word_mode), .i_req_valid(i_req_valid),
   .i_req(i_req), .i_mem_ack(i_mem_ack), .o_req_ready(o_req_ready),
   .o_mem(o_mem), .o_done(o_done), .o_acc_wr(o_acc_wr),
   .o_byte_mode(o_byte_mode), .o_overflow(o_overflow));

// File: verif/bwo_operand_access_tb.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench: one task per scenario.
// =====================================================================
module bwo_operand_access_tb;
   logic i_core_clk, i_rst_b, i_console_reset, i_req_valid; // Controls.
   logic i_set_byte_mode, i_set_word_mode, slow; // Mode pulses, latency.
   logic i_mem_ack, o_req_ready, o_done, o_acc_wr, o_byte_mode, o_overflow;
   logic [15:0] i_acc, i_mem_rdata, res, o_result, o_target, o_nba;
   bwo_pkg::bwo_req_s i_req; // Request toward the block.
   bwo_pkg::bwo_mem_s o_mem; // Read request toward memory.
   int n_mismatch, comparisons, acks, cyc; // Counters.
   bwo_operand_access uut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
      .i_console_reset(i_console_reset), .i_set_byte_mode(i_set_byte_mode),
      .i_set_word_mode(i_set_word_mode), .i_req_valid(i_req_valid),
      .i_req(i_req), .i_acc(i_acc), .i_mem_rdata(i_mem_rdata),
      .i_mem_ack(i_mem_ack), .o_req_ready(o_req_ready), .o_mem(o_mem),
      .o_done(o_done), .o_acc_wr(o_acc_wr), .o_result(o_result),
      .o_target(o_target), .o_next_byte_addr(o_nba),
      .o_byte_mode(o_byte_mode), .o_overflow(o_overflow));
   bwo_mem_model mem (.i_clk(i_core_clk), .i_rst_b(i_rst_b), .i_mem(o_mem),
      .i_slow(slow), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
   // Compares one value and counts it.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Issues one request and waits, bounded, for done; counts memory acks.
   task automatic run(input bwo_pkg::bwo_op_e op, input logic ind,
      input logic [15:0] a, input logic [15:0] acc);
      int n;
      acks = 0;
      @(posedge i_core_clk);
      i_req_valid <= 1'h1;
      i_req <= '{op, ind, a};
      i_acc <= acc;
      @(posedge i_core_clk);
      i_req_valid <= 1'h0;
      for (n = 0; n < 40; n++) begin
         #1;
         if (i_mem_ack === 1'h1) acks++;
         if (o_done === 1'h1) break;
         @(posedge i_core_clk);
      end
      check(16'(o_done), 16'h1);
      check(16'(o_req_ready), 16'h1);
      res = o_result;
   endtask : run
   // Pulses one mode control for one cycle.
   task automatic mode(input logic b);
      @(posedge i_core_clk);
      i_set_byte_mode <= b;
      i_set_word_mode <= !b;
      @(posedge i_core_clk);
      i_set_byte_mode <= 1'h0;
      i_set_word_mode <= 1'h0;
      #1 check(16'(o_byte_mode), 16'(b));
   endtask : mode
   task automatic t_word();
      run(bwo_pkg::OP_LOAD, 1'h0, 16'h0123, 16'h0000);
      check(res, 16'h96F0);
      check(o_target, 16'h0123);
   endtask : t_word
   // Byte loads, adds and subtracts, then the word-only instructions.
   task automatic t_byte();
      mode(1'h1);
      run(bwo_pkg::OP_LOAD, 1'h0, 16'h0246, 16'h0000);
      check(res, 16'h0096);
      run(bwo_pkg::OP_READ, 1'h0, 16'h0247, 16'h0000);
      check(res, 16'h00F0);
      check(o_nba, 16'h0248);
      run(bwo_pkg::OP_ADD, 1'h0, 16'h0246, 16'h0C7C);
      check(res, 16'h0D12);
      check(16'(o_acc_wr), 16'h1);
      run(bwo_pkg::OP_SUB, 1'h0, 16'h0246, 16'h0C7C);
      check(res, 16'h0BE6);
      run(bwo_pkg::OP_INCREMENT_MEMORY_SKIP_INSTR, 1'h0, 16'h0123, 16'h0);
      check(res, 16'h96F0);
      run(bwo_pkg::OP_MEMORY_SCAN_INSTR, 1'h0, 16'h0123, 16'h0000);
      check(res, 16'h96F0);
      run(bwo_pkg::OP_FETCH, 1'h0, 16'h0123, 16'h0000);
      check(res, 16'h96F0);
      run(bwo_pkg::OP_JUMP_AND_STORE_INSTR, 1'h0, 16'h0123, 16'h0000);
      check(o_target, 16'h0123);
   endtask : t_byte
   // A byte pointer is never chained; a word pointer chain is followed.
   task automatic t_indirect();
      run(bwo_pkg::OP_LOAD, 1'h1, 16'h0010, 16'h0000);
      check(res, 16'h0034);
      check(res & 16'h00FF, 16'h0034);
      check(16'(acks), 16'h2);
      mode(1'h0);
      slow = 1'h1;
      run(bwo_pkg::OP_LOAD, 1'h1, 16'h0020, 16'h0000);
      check(res, 16'h96F0);
      check(16'(acks), 16'h3);
      run(bwo_pkg::OP_JUMP_INSTR, 1'h1, 16'h0020, 16'h0000);
      check(o_target, 16'h0123);
      slow = 1'h0;
   endtask : t_indirect
   // Signed overflow on a byte add, then a processor reset clears state.
   task automatic t_reset();
      mode(1'h1);
      run(bwo_pkg::OP_ADD, 1'h0, 16'h0246, 16'h7FFF);
      check(res, 16'h8095);
      check(16'(o_overflow), 16'h1);
      @(posedge i_core_clk);
      i_console_reset <= 1'h1;
      @(posedge i_core_clk);
      i_console_reset <= 1'h0;
      #1 check(16'({o_byte_mode, o_overflow}), 16'h0);
   endtask : t_reset
   task automatic give_verdict();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   // Free-running clock at 25 MHz.
   initial begin
      i_core_clk = 1'h0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   // Cuts a hang short; the whole run needs well under 2000 cycles.
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      {i_rst_b, i_console_reset, i_req_valid, slow} = 4'h0;
      {i_set_byte_mode, i_set_word_mode} = 2'h0;
      i_req = '0;
      i_acc = 16'h0000;
      mem.words[15'h0123] = 16'h96F0;
      mem.words[15'h0010] = 16'h8247;
      mem.words[15'h4123] = 16'h1234;
      mem.words[15'h0020] = 16'h8030;
      mem.words[15'h0030] = 16'h0123;
      repeat (6) @(posedge i_core_clk);
      i_rst_b <= 1'h1;
      repeat (3) @(posedge i_core_clk);
      t_word();
      t_byte();
      t_indirect();
      t_reset();
      give_verdict();
   end
endmodule : bwo_operand_access_tb
